// >>> inc/mtm_params.svh
/*
 Register offsets, field positions, reset values and encodings of the
 8-bit modulo timer. Assumes inclusion by bare name from design files.
*/
`ifndef MTM_PARAMS_SVH
`define MTM_PARAMS_SVH

`define MTM_OFF_SC       2'h0
`define MTM_OFF_CLK      2'h1
`define MTM_OFF_CNT      2'h2
`define MTM_OFF_MOD      2'h3

`define MTM_SC_TOF       7
`define MTM_SC_IE        6
`define MTM_SC_CLR       5
`define MTM_SC_HALT      4

`define MTM_CLK_SRC_HI   5
`define MTM_CLK_SRC_LO   4
`define MTM_CLK_PS_HI    3
`define MTM_CLK_PS_LO    0

`define MTM_RST_HALT     1'b1
`define MTM_RST_IE       1'b0
`define MTM_RST_CNT      8'h00
`define MTM_RST_MOD      8'h00
`define MTM_RST_SRC      2'h0
`define MTM_RST_PS       4'h0

`define MTM_SRC_BUS      2'h0
`define MTM_SRC_FIX      2'h1
`define MTM_SRC_FALL     2'h2
`define MTM_SRC_RISE     2'h3

`define MTM_PS_MAX       4'h8
`define MTM_FREE_TOP     8'hff

`endif

// >>> inc/mtm_pkg.sv
/*
 Types shared by the modulo timer modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mtm_pkg;

   typedef enum logic [1:0] {
      MTM_STOPPED,
      MTM_FREE,
      MTM_MODULO
   } mtm_mode_t;

   typedef struct packed {
      logic [1:0] src;
      logic [3:0] ps;
   } mtm_clkcfg_t;

endpackage

// >>> design/mtm_src_select.sv
/*
 Count source selector: synchronises the two pin sources and
 yields a one-cycle event per selected source edge.
 Assumes pins are slower than half the clock rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtm_params.svh"

module mtm_src_select (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] src,
   input  wire logic       fixed_freq_clock,
   input  wire logic       ext_count_pin,
   output logic            src_evt
);
   logic [1:0] pin_in;
   logic [1:0] rise;
   logic [1:0] fall;

   assign pin_in = {ext_count_pin, fixed_freq_clock};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         logic s1_q, s2_q, s3_q;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= pin_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // Edges seen only past the second stage
         assign rise[g] = s2_q & ~s3_q;
         assign fall[g] = ~s2_q & s3_q;
      end
   endgenerate

   always_comb begin
      case (src)
         `MTM_SRC_BUS:  src_evt = 1'b1;
         `MTM_SRC_FIX:  src_evt = rise[0];
         `MTM_SRC_FALL: src_evt = fall[1];
         default:       src_evt = rise[1];
      endcase
   end
endmodule // mtm_src_select

`default_nettype wire

// >>> design/mtm_prescaler.sv
/*
 Nine-tap power-of-two prescaler after the source selector.
 Assumes src_evt is a one-cycle event in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtm_params.svh"

module mtm_prescaler #(
   parameter int PS_W = 8
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       src_evt,
   input  wire logic [3:0] ps,
   input  wire logic       run,
   input  wire logic       clr,
   output logic            tick
);
   logic [PS_W-1:0] div_q, div_d;

   generate
      if (PS_W != 8) begin : g_chk
         $error("mtm_prescaler: PS_W must be 8");
      end
   endgenerate

   // Codes at and above the top tap saturate to divide-by-256
   function automatic logic [PS_W-1:0] tap_mask(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > `MTM_PS_MAX) ? `MTM_PS_MAX : sel;
      tap_mask = PS_W'((9'h001 << s) - 9'h001);
   endfunction

   always_comb begin
      tick  = run & src_evt & ((div_q & tap_mask(ps)) == tap_mask(ps));
      div_d = div_q;
      if (clr)
         div_d = '0;
      else if (run & src_evt)
         div_d = div_q + PS_W'(1); // ratio change keeps phase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         div_q <= '0;
      else
         div_q <= div_d;
   end
endmodule // mtm_prescaler

`default_nettype wire

// >>> design/mtm_modulo_timer.sv
/*
 8-bit modulo timer top: register port, counter, overflow flag with
 two-step clear, and interrupt request.
 Assumes a master that keeps strobes one cycle and never both at once.
*/
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mtm_params.svh"

// Functional notes
// - Counter stopped, free-running or modulo; stopped after reset.
// - Reset: count and modulo zero, bus clock source, divide by 1.
// - Running with nonzero modulo is modulo mode, zero gives free-run.
// - Writing halt bit low starts counting; default is free-running.
// - Four sources: bus clock, fixed clock, pin rising, pin falling.
// - Source codes: 00 bus, 01 fixed, 10 pin falling, 11 pin rising.
// - Source change while running keeps the count.
// - Prescaler divides by 1, 2, 4 up to 256.
// - Prescale codes ascend from divide-by-1; 1000 and up give 256.
// - Prescale code 0010 divides by 4.
// - Prescale change while running keeps the count.
// - Modulo accepts 01 to FF; zero selects free-running.
// - Count increments per tick until modulo, then wraps to zero.
// - Overflow flag sets on the modulo-to-zero transition.
// - Modulo write clears flag; when running also zeroes count.
// - Flag clears by status read while set, then writing 0, or by a modulo write or counter-clear write.
// - Overflow between read and write aborts the clear.
// - Writing 1 to counter-clear also clears the flag.
// - Counter-clear write 1 zeroes count; write 0 nothing; reads 0.
// - Halt freezes count; release resumes from same value.
// - Interrupt request while flag set and enable is 1.
module mtm_modulo_timer #(
   parameter int CNT_W = 8
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       fixed_freq_clock,
   input  wire logic       ext_count_pin,
   output logic            irq
);
   logic                 halt_q, halt_d;
   logic                 ie_q, ie_d;
   logic                 tof_q, tof_d;
   logic                 arm_q, arm_d;
   logic [CNT_W-1:0]     cnt_q, cnt_d;
   logic [CNT_W-1:0]     mod_q, mod_d;
   mtm_pkg::mtm_clkcfg_t cfg_q, cfg_d;
   logic [7:0]           rdata_q, rdata_d;
   logic                 irq_q, irq_d;
   mtm_pkg::mtm_mode_t   mode;
   logic                 wr_sc, wr_clk, wr_mod, rd_sc;
   logic                 clr_cnt, mod_zero, ovf;
   logic                 src_evt, tick;
   logic [CNT_W-1:0]     top;

   generate
      if (CNT_W != 8) begin : g_chk
         $error("mtm_modulo_timer: CNT_W must be 8");
      end
   endgenerate

   function automatic logic hit(input logic strobe, input logic [1:0] a,
                                input logic [1:0] off);
      hit = strobe & (a == off);
   endfunction

   assign wr_sc   = hit(wr, addr, `MTM_OFF_SC);
   assign wr_clk  = hit(wr, addr, `MTM_OFF_CLK);
   assign wr_mod  = hit(wr, addr, `MTM_OFF_MOD);
   assign rd_sc   = hit(rd, addr, `MTM_OFF_SC);
   assign clr_cnt = wr_sc & wdata[`MTM_SC_CLR];
   // Modulo write while stopped leaves the count alone
   assign mod_zero = wr_mod & ~halt_q;

   mtm_src_select u_src (
      .clk              (clk),
      .rst              (rst),
      .src              (cfg_q.src),
      .fixed_freq_clock (fixed_freq_clock),
      .ext_count_pin    (ext_count_pin),
      .src_evt          (src_evt)
   );

   mtm_prescaler #(.PS_W(8)) u_ps (
      .clk     (clk),
      .rst     (rst),
      .src_evt (src_evt),
      .ps      (cfg_q.ps),
      .run     (~halt_q),
      .clr     (clr_cnt | mod_zero),
      .tick    (tick)
   );

   always_comb begin
      if (halt_q)
         mode = mtm_pkg::MTM_STOPPED;
      else if (mod_q == '0)
         mode = mtm_pkg::MTM_FREE;
      else
         mode = mtm_pkg::MTM_MODULO;
   end

   // Counter and configuration
   always_comb begin
      case (mode)
         mtm_pkg::MTM_MODULO: top = mod_q;
         mtm_pkg::MTM_FREE:   top = `MTM_FREE_TOP;
         default:             top = `MTM_FREE_TOP;
      endcase
      ovf    = tick & (cnt_q == top);
      cnt_d  = cnt_q;
      if (clr_cnt | mod_zero)
         cnt_d = '0;
      else if (tick)
         cnt_d = ovf ? '0 : cnt_q + CNT_W'(1);
      halt_d = halt_q;
      ie_d   = ie_q;
      if (wr_sc) begin
         halt_d = wdata[`MTM_SC_HALT];
         ie_d   = wdata[`MTM_SC_IE];
      end
      // Source and ratio change leave the count untouched
      cfg_d = wr_clk ? mtm_pkg::mtm_clkcfg_t'(wdata[`MTM_CLK_SRC_HI:`MTM_CLK_PS_LO]) : cfg_q;
      mod_d = wr_mod ? wdata : mod_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         halt_q    <= `MTM_RST_HALT;
         ie_q      <= `MTM_RST_IE;
         cnt_q     <= `MTM_RST_CNT;
         mod_q     <= `MTM_RST_MOD;
         cfg_q.src <= `MTM_RST_SRC;
         cfg_q.ps  <= `MTM_RST_PS;
      end else begin
         halt_q <= halt_d;
         ie_q   <= ie_d;
         cnt_q  <= cnt_d;
         mod_q  <= mod_d;
         cfg_q  <= cfg_d;
      end
   end

   // Overflow flag and its two-step clear
   always_comb begin
      arm_d = arm_q;
      if (ovf)
         arm_d = 1'b0;
      else if (rd_sc & tof_q)
         arm_d = 1'b1;
      else if (wr_sc)
         arm_d = 1'b0;
      tof_d = tof_q;
      // A fresh overflow beats every clear in the same cycle
      if (ovf)
         tof_d = 1'b1;
      else if (clr_cnt | wr_mod)
         tof_d = 1'b0;
      else if (wr_sc & ~wdata[`MTM_SC_TOF] & arm_q)
         tof_d = 1'b0;
      irq_d = tof_d & ie_d;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tof_q <= 1'b0;
         arm_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         tof_q <= tof_d;
         arm_q <= arm_d;
         irq_q <= irq_d;
      end
   end

   // Read port: data in the cycle after the strobe only
   always_comb begin
      rdata_d = 8'h00;
      if (rd) begin
         case (addr)
            `MTM_OFF_SC:  rdata_d = {tof_q, ie_q, 1'b0, halt_q, 4'h0};
            `MTM_OFF_CLK: rdata_d = {2'h0, cfg_q};
            `MTM_OFF_CNT: rdata_d = cnt_q;
            `MTM_OFF_MOD: rdata_d = mod_q;
            default:      rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   assign rdata = rdata_q;
   assign irq   = irq_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_ovf_sets_flag: assert property (ovf |=> tof_q)
      else $error("overflow did not set flag");

   chk_wrap_to_zero: assert property (
      ovf && !clr_cnt && !mod_zero |=> cnt_q == 8'h00)
      else $error("count did not wrap to zero");

   chk_count_step: assert property (
      tick && !ovf && !clr_cnt && !mod_zero |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("count did not step by one");

   chk_halt_freeze: assert property (
      halt_q && !clr_cnt && !wr_mod |=> $stable(cnt_q))
      else $error("halted count moved");

   chk_mod_write: assert property (
      wr_mod && !halt_q |=> cnt_q == 8'h00 && tof_q == $past(ovf))
      else $error("modulo write did not restart");

   chk_clear_bit: assert property (
      clr_cnt |=> cnt_q == 8'h00 && tof_q == $past(ovf))
      else $error("counter clear failed");

   chk_arm_needs_read: assert property (
      !arm_q && !(rd_sc && tof_q) |=> !arm_q)
      else $error("clear armed without status read");

   chk_unarmed_hold: assert property (
      tof_q && !arm_q && wr_sc && !clr_cnt |=> tof_q)
      else $error("flag cleared without read step");

   chk_free_wrap: assert property (
      tick && mod_q == 8'h00 && cnt_q == 8'hff |=> tof_q && cnt_q == 8'h00)
      else $error("free-run wrap failed");

   chk_irq_level: assert property (irq_q == (tof_q && ie_q))
      else $error("interrupt request mismatch");

   chk_clr_reads_zero: assert property (rd_sc |=> rdata_q[`MTM_SC_CLR] == 1'b0)
      else $error("clear bit read back as one");

   chk_halt_no_tick: assert property (
      halt_q |-> !tick)
      else $error("tick while halted");

   chk_tick_needs_src: assert property (
      tick |-> src_evt)
      else $error("tick without source event");

   chk_bus_div_one: assert property (
      !halt_q && cfg_q.src == `MTM_SRC_BUS && cfg_q.ps == 4'h0 |-> tick)
      else $error("bus clock by one missed a tick");

   chk_ovf_disarms: assert property (
      ovf |=> !arm_q)
      else $error("overflow left clear armed");

   chk_one_keeps_flag: assert property (
      wr_sc && wdata[`MTM_SC_TOF] && tof_q && !clr_cnt |=> tof_q)
      else $error("writing one cleared flag");

   chk_modulo_wrap: assert property (
      tick && mod_q != 8'h00 && cnt_q == mod_q && !clr_cnt && !mod_zero |=> cnt_q == 8'h00 && tof_q)
      else $error("modulo match did not wrap");

   chk_count_idle: assert property (
      !tick && !clr_cnt && !mod_zero |=> $stable(cnt_q))
      else $error("count moved without tick");

   chk_cfg_keeps_count: assert property (
      wr_clk && !tick |=> $stable(cnt_q))
      else $error("clock config write moved count");

   chk_halt_set: assert property (
      wr_sc && wdata[`MTM_SC_HALT] |=> halt_q)
      else $error("halt bit not taken");

   chk_halt_clear: assert property (
      wr_sc && !wdata[`MTM_SC_HALT] |=> !halt_q)
      else $error("start not taken");

   chk_halt_hold: assert property (
      !wr_sc |=> $stable(halt_q))
      else $error("halt bit moved without write");

   chk_ie_write: assert property (
      wr_sc |=> ie_q == $past(wdata[`MTM_SC_IE]))
      else $error("enable bit not taken");

   chk_ovf_needs_run: assert property (
      ovf |-> tick && !halt_q)
      else $error("overflow without running tick");

   chk_mod_load: assert property (
      wr_mod |=> mod_q == $past(wdata))
      else $error("modulo value not taken");

   chk_cfg_load: assert property (
      wr_clk |=> cfg_q == $past(wdata[`MTM_CLK_SRC_HI:`MTM_CLK_PS_LO]))
      else $error("clock config not taken");

   chk_rd_count: assert property (
      rd && addr == `MTM_OFF_CNT |=> rdata_q == $past(cnt_q))
      else $error("count read wrong");

   chk_rd_modulo: assert property (
      rd && addr == `MTM_OFF_MOD |=> rdata_q == $past(mod_q))
      else $error("modulo read wrong");

   chk_rd_config: assert property (
      rd && addr == `MTM_OFF_CLK |=> rdata_q == {2'h0, $past(cfg_q)})
      else $error("clock config read wrong");

   chk_rd_idle: assert property (
      !rd |=> rdata_q == 8'h00)
      else $error("read data outside read slot");

   chk_irq_rise_enabled: assert property (
      $rose(irq_q) |-> ie_q)
      else $error("interrupt rose while disabled");

   chk_irq_off_disabled: assert property (
      !ie_q |-> !irq_q)
      else $error("interrupt high while disabled");

   chk_flag_needs_ovf: assert property (
      !tof_q && !ovf |=> !tof_q)
      else $error("flag set without overflow");

   chk_flag_holds: assert property (
      tof_q && !clr_cnt && !wr_mod && !(wr_sc && arm_q && !wdata[`MTM_SC_TOF]) |=> tof_q)
      else $error("flag cleared without clear step");

endmodule // mtm_modulo_timer

`default_nettype wire

// >>> verif/tb.sv
/*
 Self-checking bench for the 8-bit modulo timer top.
 Assumes mtm_params.svh on the include path and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtm_params.svh"

module tb;
   logic       clk;
   logic       rst;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       fixed_freq_clock;
   logic       ext_count_pin;
   logic       irq;
   int         fails;
   int         num_checks;
   int         cycles;

   mtm_modulo_timer i_dut (
      .clk              (clk),
      .rst              (rst),
      .addr             (addr),
      .wdata            (wdata),
      .wr               (wr),
      .rd               (rd),
      .rdata            (rdata),
      .fixed_freq_clock (fixed_freq_clock),
      .ext_count_pin    (ext_count_pin),
      .irq              (irq)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic conclude();
      $display("Checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Generous ceiling: the full run needs about 2850 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string name, input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(name, rdata, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Four cycles per level: the synchroniser needs three to see a change
   task automatic pulse(input bit fixed, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         ext_count_pin    <= !fixed;
         fixed_freq_clock <= fixed;
         repeat (4) @(posedge clk);
         ext_count_pin    <= 1'b0;
         fixed_freq_clock <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic t_reset();
      rd_chk("sc", `MTM_OFF_SC, 8'h10);
      rd_chk("clk", `MTM_OFF_CLK, 8'h00);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      rd_chk("mod", `MTM_OFF_MOD, 8'h00);
      idle(1);
      #1;
      chk("rdata_idle", rdata, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
   endtask

   // Start-to-halt spacing of n idle cycles yields n+2 increments
   task automatic t_free();
      wr_reg(`MTM_OFF_CNT, 8'h55);
      wr_reg(`MTM_OFF_SC, 8'h00);
      idle(3);
      wr_reg(`MTM_OFF_SC, 8'h10);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h05);
      idle(5);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h05);
      wr_reg(`MTM_OFF_SC, 8'h00);
      idle(254);
      wr_reg(`MTM_OFF_SC, 8'h10);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h05);
      rd_chk("sc", `MTM_OFF_SC, 8'h90);
      wr_reg(`MTM_OFF_SC, 8'h10);
      rd_chk("sc", `MTM_OFF_SC, 8'h10);
   endtask

   task automatic t_modulo();
      wr_reg(`MTM_OFF_MOD, 8'h03);
      wr_reg(`MTM_OFF_SC, 8'h30);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      rd_chk("mod", `MTM_OFF_MOD, 8'h03);
      wr_reg(`MTM_OFF_SC, 8'h00);
      idle(3);
      wr_reg(`MTM_OFF_SC, 8'h10);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h01);
      rd_chk("sc", `MTM_OFF_SC, 8'h90);
      wr_reg(`MTM_OFF_SC, 8'h10);
      wr_reg(`MTM_OFF_SC, 8'h40);
      idle(1);
      wr_reg(`MTM_OFF_SC, 8'h50);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      chk("irq", {7'h00, irq}, 8'h01);
      wr_reg(`MTM_OFF_SC, 8'h70);
      rd_chk("sc", `MTM_OFF_SC, 8'h50);
      chk("irq", {7'h00, irq}, 8'h00);
      wr_reg(`MTM_OFF_SC, 8'h10);
   endtask

   task automatic t_pin();
      wr_reg(`MTM_OFF_CLK, 8'h30);
      wr_reg(`MTM_OFF_MOD, 8'h01);
      wr_reg(`MTM_OFF_SC, 8'h00);
      pulse(1'b0, 2);
      rd_chk("sc", `MTM_OFF_SC, 8'h80);
      pulse(1'b0, 2);
      wr_reg(`MTM_OFF_SC, 8'h00);
      rd_chk("sc", `MTM_OFF_SC, 8'h80);
      pulse(1'b0, 1);
      wr_reg(`MTM_OFF_CLK, 8'h20);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h01);
      pulse(1'b0, 1);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      pulse(1'b0, 1);
      wr_reg(`MTM_OFF_MOD, 8'h00);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      rd_chk("sc", `MTM_OFF_SC, 8'h00);
      wr_reg(`MTM_OFF_CLK, 8'h10);
      pulse(1'b1, 3);
      pulse(1'b0, 1);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h03);
   endtask

   // Modulo writes while running restart the prescaler so tick counts are exact
   task automatic t_prescale();
      wr_reg(`MTM_OFF_CLK, 8'h32);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h03);
      wr_reg(`MTM_OFF_MOD, 8'h00);
      pulse(1'b0, 3);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      pulse(1'b0, 1);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h01);
      wr_reg(`MTM_OFF_CLK, 8'h3f);
      wr_reg(`MTM_OFF_MOD, 8'h00);
      pulse(1'b0, 255);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h00);
      pulse(1'b0, 1);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h01);
      wr_reg(`MTM_OFF_SC, 8'h10);
      wr_reg(`MTM_OFF_CLK, 8'h03);
      wr_reg(`MTM_OFF_SC, 8'h30);
      wr_reg(`MTM_OFF_SC, 8'h00);
      idle(14);
      wr_reg(`MTM_OFF_SC, 8'h10);
      rd_chk("cnt", `MTM_OFF_CNT, 8'h02);
   endtask

   initial begin
      rst              = 1'b1;
      addr             = 2'h0;
      wdata            = 8'h00;
      wr               = 1'b0;
      rd               = 1'b0;
      fixed_freq_clock = 1'b0;
      ext_count_pin    = 1'b0;
      fails            = 0;
      num_checks       = 0;
      cycles           = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_free();
      t_modulo();
      t_pin();
      t_prescale();
      conclude();
   end
endmodule // tb

`default_nettype wire
